// >>> hdl/mps_map.vh
// mps_map.vh - constants for the mode, privilege and stack select block
// assumes it is included by bare name from the hdl/ design files
`ifndef MPS_MAP_VH
`define MPS_MAP_VH

// ---------------------------------------------------------------
// control value fields and reset value
// ---------------------------------------------------------------
`define MPS_CTRL_NPRIV_BIT 0
`define MPS_CTRL_SPSEL_BIT 1
`define MPS_CTRL_RST       2'h0

// ---------------------------------------------------------------
// reset stack load and stack step
// ---------------------------------------------------------------
`define MPS_RESET_SP_ADDR 32'h00000000
`define MPS_WORD_BYTES    32'h00000004
`define MPS_WORD_MASK     32'hFFFFFFFC

// ---------------------------------------------------------------
// instruction classes
// ---------------------------------------------------------------
`define MPS_IC_OTHER    3'h0
`define MPS_IC_IRQ_MASK 3'h1
`define MPS_IC_SREG_RD  3'h2
`define MPS_IC_SREG_WR  3'h3
`define MPS_IC_SVC      3'h4

// ---------------------------------------------------------------
// special register selectors
// ---------------------------------------------------------------
`define MPS_SR_APSR    8'h00
`define MPS_SR_MSP     8'h08
`define MPS_SR_PSP     8'h09
`define MPS_SR_CONTROL 8'h14

// ---------------------------------------------------------------
// privileged-only regions: tick timer, irq ctrl, sys ctrl block
// ---------------------------------------------------------------
`define MPS_TICK_BASE 32'h00001000
`define MPS_TICK_LAST 32'h000010FF
`define MPS_NIC_BASE  32'h00002000
`define MPS_NIC_LAST  32'h00002FFF
`define MPS_SCB_BASE  32'h00003000
`define MPS_SCB_LAST  32'h000030FF

// ---------------------------------------------------------------
// boot sequencer states
// ---------------------------------------------------------------
`define MPS_ST_BOOT  2'h0
`define MPS_ST_FETCH 2'h1
`define MPS_ST_RUN   2'h2

`endif

// >>> hdl/mps_access_check.v
// mps_access_check.v - combinational privilege checks
// assumes i_priv is the current registered privilege of the core
`timescale 1ns/10ps
`include "mps_map.vh"

module mps_access_check #(
   parameter NREG = 3
) (
   input  wire        i_priv,
   input  wire        i_instr_valid,
   input  wire [2:0]  i_instr_class,
   input  wire [7:0]  i_instr_sreg,
   input  wire        i_acc_valid,
   input  wire [31:0] i_acc_addr,
   output wire        o_instr_fault,
   output wire        o_acc_fault,
   output wire        o_svc
);
   // ------------------------------------------------------------
   // privileged-only region match
   // ------------------------------------------------------------
   localparam [32*NREG-1:0] BASES = {`MPS_SCB_BASE, `MPS_NIC_BASE, `MPS_TICK_BASE};
   localparam [32*NREG-1:0] LASTS = {`MPS_SCB_LAST, `MPS_NIC_LAST, `MPS_TICK_LAST};
   wire [NREG-1:0] hit;
   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1) begin : g_reg
         assign hit[g] = (i_acc_addr >= BASES[32*g+31:32*g]) &&
                         (i_acc_addr <= LASTS[32*g+31:32*g]);
      end
   endgenerate
   assign o_acc_fault = i_acc_valid & ~i_priv & (|hit);

   // ------------------------------------------------------------
   // instruction checks; unprivileged may touch only a few registers
   // ------------------------------------------------------------
   wire rd_ok = (i_instr_sreg == `MPS_SR_APSR) || (i_instr_sreg == `MPS_SR_PSP) ||
                (i_instr_sreg == `MPS_SR_CONTROL);
   wire wr_ok = (i_instr_sreg == `MPS_SR_APSR) || (i_instr_sreg == `MPS_SR_PSP);
   wire bad_mask = (i_instr_class == `MPS_IC_IRQ_MASK);
   wire bad_rd   = (i_instr_class == `MPS_IC_SREG_RD) & ~rd_ok;
   wire bad_wr   = (i_instr_class == `MPS_IC_SREG_WR) & ~wr_ok;
   // privileged code never faults here
   assign o_instr_fault = i_instr_valid & ~i_priv & (bad_mask | bad_rd | bad_wr);
   assign o_svc = i_instr_valid & (i_instr_class == `MPS_IC_SVC);
endmodule // mps_access_check

// >>> hdl/mps_stack_ptrs.v
// mps_stack_ptrs.v - main and process stack pointers with push and pop
// assumes requests are already qualified by the core-ready state
`timescale 1ns/10ps
`include "mps_map.vh"

module mps_stack_ptrs (
   input  wire        i_sys_clk,
   input  wire        i_rst,
   input  wire        i_load_msp,
   input  wire [31:0] i_load_data,
   input  wire        i_wr_msp,
   input  wire        i_wr_psp,
   input  wire [31:0] i_wr_data,
   input  wire        i_use_psp,
   input  wire        i_nxt_use_psp,
   input  wire        i_push,
   input  wire [31:0] i_push_data,
   input  wire        i_pop,
   output reg  [31:0] o_msp,
   output reg  [31:0] o_psp,
   output reg  [31:0] o_active_sp,
   output reg         o_wr_en,
   output reg  [31:0] o_wr_addr,
   output reg  [31:0] o_wr_data
);
   reg  [31:0] nxt_msp;
   reg  [31:0] nxt_psp;
   wire [31:0] cur = i_use_psp ? o_psp : o_msp;
   wire [31:0] dec = cur - `MPS_WORD_BYTES; // full descending: step down first
   wire [31:0] inc = cur + `MPS_WORD_BYTES;

   // next pointers; explicit writes win over push and pop
   always @* begin
      nxt_msp = o_msp;
      nxt_psp = o_psp;
      if (i_push) begin
         if (i_use_psp) nxt_psp = dec;
         else nxt_msp = dec;
      end else if (i_pop) begin
         if (i_use_psp) nxt_psp = inc;
         else nxt_msp = inc;
      end
      if (i_wr_msp) nxt_msp = i_wr_data & `MPS_WORD_MASK;
      if (i_wr_psp) nxt_psp = i_wr_data & `MPS_WORD_MASK;
      if (i_load_msp) nxt_msp = i_load_data & `MPS_WORD_MASK;
   end

   // two independent copies, the active one mirrored in a flop
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_msp       <= 32'h00000000;
         o_psp       <= 32'h00000000;
         o_active_sp <= 32'h00000000;
         o_wr_en     <= 1'b0;
         o_wr_addr   <= 32'h00000000;
         o_wr_data   <= 32'h00000000;
      end else begin
         o_msp       <= nxt_msp;
         o_psp       <= nxt_psp;
         o_active_sp <= i_nxt_use_psp ? nxt_psp : nxt_msp;
         o_wr_en     <= i_push;
         o_wr_addr   <= i_push ? dec : o_wr_addr;
         o_wr_data   <= i_push ? i_push_data : o_wr_data;
      end
   end
endmodule // mps_stack_ptrs

// >>> hdl/mps_top.v
// mps_top.v - processor mode, execution privilege and stack select
// assumes a core clock, a synchronous reset and an exception unit that
// pulses entry and return; the vector memory answers with a valid pulse
`timescale 1ns/10ps
`include "mps_map.vh"

module mps_top #(
   parameter NEST_W = 8
) (
   input  wire              i_sys_clk,
   input  wire              i_rst,
   // reset vector fetch
   input  wire              i_vec_rd_valid,
   input  wire [31:0]       i_vec_rd_data,
   output reg               o_vec_rd_req,
   output reg  [31:0]       o_vec_rd_addr,
   // exception unit
   input  wire              i_exc_entry,
   input  wire              i_exc_return,
   // decoded instruction
   input  wire              i_instr_valid,
   input  wire [2:0]        i_instr_class,
   input  wire [7:0]        i_instr_sreg,
   input  wire [31:0]       i_instr_sreg_data,
   // data access check
   input  wire              i_acc_valid,
   input  wire [31:0]       i_acc_addr,
   // stack operations
   input  wire              i_push,
   input  wire [31:0]       i_push_data,
   input  wire              i_pop,
   // state
   output reg               o_core_ready,
   output reg               o_handler_mode,
   output reg               o_privileged,
   output reg               o_use_psp,
   output reg  [1:0]        o_ctrl_value,
   output reg  [NEST_W-1:0] o_nest_depth,
   // check results
   output reg               o_instr_fault,
   output reg               o_acc_fault,
   output reg               o_svc_req,
   output reg               o_ctrl_wr_refused,
   // stack pointers and push writes
   output wire [31:0]       o_main_stack_ptr,
   output wire [31:0]       o_process_stack_ptr,
   output wire [31:0]       o_active_sp,
   output wire              o_stack_wr_en,
   output wire [31:0]       o_stack_wr_addr,
   output wire [31:0]       o_stack_wr_data
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   localparam [NEST_W-1:0] DEPTH_ZERO = {NEST_W{1'b0}};
   localparam [NEST_W-1:0] DEPTH_ONE  = {{(NEST_W-1){1'b0}}, 1'b1};
   localparam [NEST_W-1:0] DEPTH_MAX  = {NEST_W{1'b1}};

   reg  [1:0]        state_ff;
   reg  [1:0]        nxt_state;
   reg  [NEST_W-1:0] nxt_depth;
   reg  [1:0]        nxt_ctrl;
   reg               nxt_req;
   wire              nxt_handler;
   wire              nxt_priv;
   wire              nxt_use_psp;
   wire              vec_take;
   wire              run;
   wire              instr_ok;
   wire              chk_instr_fault;
   wire              chk_acc_fault;
   wire              chk_svc;
   wire              sreg_wr;
   wire              ctrl_wr;
   wire              wr_msp;
   wire              wr_psp;
   wire              push_go;
   wire              pop_go;
   wire              entry_go;
   wire              ret_go;

   // ------------------------------------------------------------
   // boot sequencer: fetch the initial main stack pointer
   // ------------------------------------------------------------
   // the answer is only taken while the request is standing
   assign vec_take = o_vec_rd_req & i_vec_rd_valid;
   assign run      = (state_ff == `MPS_ST_RUN);

   // next state of the boot sequencer
   always @* begin
      nxt_state = state_ff;
      nxt_req   = o_vec_rd_req;
      case (state_ff)
         `MPS_ST_BOOT: begin
            nxt_state = `MPS_ST_FETCH;
            nxt_req   = 1'b1;
         end
         `MPS_ST_FETCH: begin
            if (vec_take) begin
               nxt_state = `MPS_ST_RUN;
               nxt_req   = 1'b0;
            end
         end
         `MPS_ST_RUN: begin
            nxt_req = 1'b0;
         end
         default: begin
            nxt_state = `MPS_ST_BOOT;
            nxt_req   = 1'b0;
         end
      endcase
   end

   // sequencer flops
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_ff      <= `MPS_ST_BOOT;
         o_vec_rd_req  <= 1'b0;
         o_vec_rd_addr <= `MPS_RESET_SP_ADDR;
         o_core_ready  <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         o_vec_rd_req  <= nxt_req;
         o_vec_rd_addr <= `MPS_RESET_SP_ADDR;
         o_core_ready  <= (nxt_state == `MPS_ST_RUN);
      end
   end

   // ------------------------------------------------------------
   // exception nesting and processor mode
   // ------------------------------------------------------------
   // nothing executes, so no exception is taken, before the boot load
   assign entry_go = run & i_exc_entry;
   assign ret_go   = run & i_exc_return;

   // entry and return together are a tail chain: depth stays put;
   // a counter at its limit saturates rather than wrapping to thread
   always @* begin
      nxt_depth = o_nest_depth;
      if (entry_go && !ret_go && o_nest_depth != DEPTH_MAX) begin
         nxt_depth = o_nest_depth + DEPTH_ONE;
      end else if (ret_go && !entry_go && o_nest_depth != DEPTH_ZERO) begin
         nxt_depth = o_nest_depth - DEPTH_ONE;
      end
   end

   // back in thread mode only when the outermost handler returns
   assign nxt_handler = (nxt_depth != DEPTH_ZERO);

   // ------------------------------------------------------------
   // privilege and access checks
   // ------------------------------------------------------------
   // checks use the privilege in force for the instruction now issuing
   mps_access_check #(
      .NREG (3)
   ) i_mps_access_check (
      .i_priv        (o_privileged),
      .i_instr_valid (instr_ok),
      .i_instr_class (i_instr_class),
      .i_instr_sreg  (i_instr_sreg),
      .i_acc_valid   (run & i_acc_valid),
      .i_acc_addr    (i_acc_addr),
      .o_instr_fault (chk_instr_fault),
      .o_acc_fault   (chk_acc_fault),
      .o_svc         (chk_svc)
   );

   assign instr_ok = run & i_instr_valid;
   assign sreg_wr  = instr_ok & (i_instr_class == `MPS_IC_SREG_WR) & ~chk_instr_fault;

   // only privileged code may change the control value
   assign ctrl_wr = sreg_wr & (i_instr_sreg == `MPS_SR_CONTROL) & o_privileged;
   assign wr_msp  = sreg_wr & (i_instr_sreg == `MPS_SR_MSP);
   assign wr_psp  = sreg_wr & (i_instr_sreg == `MPS_SR_PSP);

   // next control value
   always @* begin
      nxt_ctrl = o_ctrl_value;
      if (ctrl_wr) begin
         nxt_ctrl = i_instr_sreg_data[1:0];
      end
   end

   // handler forces privilege and the main stack whatever control says
   assign nxt_priv    = nxt_handler | ~nxt_ctrl[`MPS_CTRL_NPRIV_BIT];
   assign nxt_use_psp = ~nxt_handler & nxt_ctrl[`MPS_CTRL_SPSEL_BIT];

   // ------------------------------------------------------------
   // mode, privilege and result flops
   // ------------------------------------------------------------
   // mode, privilege and stack select are next-state registered so they match the pointers
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_nest_depth      <= DEPTH_ZERO;
         o_handler_mode    <= 1'b0;
         o_ctrl_value      <= `MPS_CTRL_RST;
         o_privileged      <= 1'b1;
         o_use_psp         <= 1'b0;
         o_instr_fault     <= 1'b0;
         o_acc_fault       <= 1'b0;
         o_svc_req         <= 1'b0;
         o_ctrl_wr_refused <= 1'b0;
      end else begin
         o_nest_depth      <= nxt_depth;
         o_handler_mode    <= nxt_handler;
         o_ctrl_value      <= nxt_ctrl;
         o_privileged      <= nxt_priv;
         o_use_psp         <= nxt_use_psp;
         o_instr_fault     <= chk_instr_fault;
         o_acc_fault       <= chk_acc_fault;
         o_svc_req         <= chk_svc;
         o_ctrl_wr_refused <= instr_ok & (i_instr_class == `MPS_IC_SREG_WR) &
                              (i_instr_sreg == `MPS_SR_CONTROL) & ~o_privileged;
      end
   end

   // ------------------------------------------------------------
   // stack pointers
   // ------------------------------------------------------------
   // push has priority over pop in the same cycle; both wait for boot
   assign push_go = run & i_push;
   assign pop_go  = run & i_pop & ~i_push;

   mps_stack_ptrs i_mps_stack_ptrs (
      .i_sys_clk     (i_sys_clk),
      .i_rst         (i_rst),
      .i_load_msp    (vec_take),
      .i_load_data   (i_vec_rd_data),
      .i_wr_msp      (wr_msp),
      .i_wr_psp      (wr_psp),
      .i_wr_data     (i_instr_sreg_data),
      .i_use_psp     (o_use_psp),
      .i_nxt_use_psp (nxt_use_psp),
      .i_push        (push_go),
      .i_push_data   (i_push_data),
      .i_pop         (pop_go),
      .o_msp         (o_main_stack_ptr),
      .o_psp         (o_process_stack_ptr),
      .o_active_sp   (o_active_sp),
      .o_wr_en       (o_stack_wr_en),
      .o_wr_addr     (o_stack_wr_addr),
      .o_wr_data     (o_stack_wr_data)
   );

endmodule // mps_top

// >>> verif/mps_top_properties.sv
// mps_top_properties.sv - concurrent checks on mode, privilege and stack select
// assumes it is bound to mps_top and sees only that module's ports
`timescale 1ns/10ps
`include "mps_map.vh"

module mps_top_properties #(
   parameter NEST_W = 8
) (
   input wire logic              i_sys_clk,
   input wire logic              i_rst,
   input wire logic              i_vec_rd_valid,
   input wire logic [31:0]       i_vec_rd_data,
   input wire logic              o_vec_rd_req,
   input wire logic              i_exc_entry,
   input wire logic              i_exc_return,
   input wire logic              i_instr_valid,
   input wire logic [2:0]        i_instr_class,
   input wire logic              i_acc_valid,
   input wire logic [31:0]       i_acc_addr,
   input wire logic              i_push,
   input wire logic [31:0]       i_push_data,
   input wire logic              o_core_ready,
   input wire logic              o_handler_mode,
   input wire logic              o_privileged,
   input wire logic              o_use_psp,
   input wire logic [1:0]        o_ctrl_value,
   input wire logic [NEST_W-1:0] o_nest_depth,
   input wire logic              o_instr_fault,
   input wire logic              o_acc_fault,
   input wire logic              o_svc_req,
   input wire logic [31:0]       o_main_stack_ptr,
   input wire logic [31:0]       o_active_sp,
   input wire logic              o_stack_wr_en,
   input wire logic [31:0]       o_stack_wr_addr,
   input wire logic [31:0]       o_stack_wr_data
);
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // access hits one of the privileged-only windows
   wire prot_hit = (i_acc_addr >= `MPS_TICK_BASE && i_acc_addr <= `MPS_TICK_LAST) ||
                   (i_acc_addr >= `MPS_NIC_BASE && i_acc_addr <= `MPS_NIC_LAST) ||
                   (i_acc_addr >= `MPS_SCB_BASE && i_acc_addr <= `MPS_SCB_LAST);
   // a push with nothing else moving the pointers or the selection
   wire lone_push = o_core_ready && i_push && !i_instr_valid && !i_exc_entry && !i_exc_return;

   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   property p_boot_load;
      o_vec_rd_req && i_vec_rd_valid |=> o_core_ready && !o_vec_rd_req && !o_handler_mode &&
         o_main_stack_ptr == ($past(i_vec_rd_data) & `MPS_WORD_MASK);
   endproperty
   a_boot_load: assert property (p_boot_load) else $error("boot load wrong");
   property p_entry;
      o_core_ready && i_exc_entry && !i_exc_return && o_nest_depth != {NEST_W{1'b1}} |=>
         o_handler_mode && o_nest_depth == $past(o_nest_depth) + 1'b1;
   endproperty
   a_entry: assert property (p_entry) else $error("entry wrong");
   property p_return;
      o_core_ready && i_exc_return && !i_exc_entry && o_nest_depth == 1 |=> !o_handler_mode;
   endproperty
   a_return: assert property (p_return) else $error("return wrong");
   property p_handler_sel;
      o_handler_mode |-> o_privileged && !o_use_psp;
   endproperty
   a_handler_sel: assert property (p_handler_sel) else $error("handler select");
   property p_thread_sel;
      o_core_ready && !o_handler_mode |->
         o_privileged == !o_ctrl_value[0] && o_use_psp == o_ctrl_value[1];
   endproperty
   a_thread_sel: assert property (p_thread_sel) else $error("thread select");
   property p_acc;
      o_core_ready && i_acc_valid |=> o_acc_fault == $past(prot_hit && !o_privileged);
   endproperty
   a_acc: assert property (p_acc) else $error("access check wrong");
   property p_mask;
      o_core_ready && i_instr_valid && i_instr_class == `MPS_IC_IRQ_MASK |=>
         o_instr_fault == $past(!o_privileged);
   endproperty
   a_mask: assert property (p_mask) else $error("mask change check wrong");
   property p_svc;
      o_core_ready && i_instr_valid && i_instr_class == `MPS_IC_SVC |=>
         o_svc_req && !o_instr_fault;
   endproperty
   a_svc: assert property (p_svc) else $error("supervisor call wrong");
   property p_push;
      lone_push |=> o_stack_wr_en && o_stack_wr_addr == $past(o_active_sp) - 32'h4 &&
         o_active_sp == o_stack_wr_addr && o_stack_wr_data == $past(i_push_data);
   endproperty
   a_push: assert property (p_push) else $error("push wrong");
   property p_msp_kept;
      lone_push && o_use_psp |=> $stable(o_main_stack_ptr);
   endproperty
   a_msp_kept: assert property (p_msp_kept) else $error("main pointer moved");

   // main scenarios reached
   c_entry: cover property (o_core_ready && i_exc_entry);
   c_psp_push: cover property (lone_push && o_use_psp);
   c_acc_fault: cover property (o_acc_fault);
   c_svc: cover property (o_svc_req);
endmodule // mps_top_properties

bind mps_top mps_top_properties #(.NEST_W(NEST_W)) i_mps_top_properties (.*);

// >>> verif/cpu_mode_privilege_stack_select_tb.sv
// cpu_mode_privilege_stack_select_tb.sv - directed bench for mps_top
// assumes mps_map.vh is on the include path and the checker is compiled too
`timescale 1ns/10ps
`include "mps_map.vh"

module cpu_mode_privilege_stack_select_tb;
   logic        i_sys_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_vec_rd_valid = 1'b0, i_exc_entry = 1'b0, i_exc_return = 1'b0;
   logic        i_instr_valid = 1'b0, i_acc_valid = 1'b0, i_push = 1'b0, i_pop = 1'b0;
   logic [2:0]  i_instr_class = 3'h0;
   logic [7:0]  i_instr_sreg = 8'h00;
   logic [31:0] i_vec_rd_data = 32'h0, i_instr_sreg_data = 32'h0;
   logic [31:0] i_acc_addr = 32'h0, i_push_data = 32'h0;
   wire         o_vec_rd_req, o_core_ready, o_handler_mode, o_privileged, o_use_psp;
   wire         o_instr_fault, o_acc_fault, o_svc_req, o_ctrl_wr_refused, o_stack_wr_en;
   wire [1:0]   o_ctrl_value;
   wire [7:0]   o_nest_depth;
   wire [31:0]  o_vec_rd_addr, o_main_stack_ptr, o_process_stack_ptr, o_active_sp;
   wire [31:0]  o_stack_wr_addr, o_stack_wr_data;
   int          bad_count = 0;
   int          num_checks = 0;

   mps_top #(.NEST_W(8)) i_mps_top (.*);

   // 200 MHz core clock
   always #2.5 i_sys_clk = ~i_sys_clk;

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task conclude;
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // every request is a one-cycle pulse; results are looked at one cycle on
   task ins(input logic [2:0] c, input logic [7:0] s, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_instr_valid <= 1'b1;
      i_instr_class <= c;
      i_instr_sreg <= s;
      i_instr_sreg_data <= d;
      @(posedge i_sys_clk);
      i_instr_valid <= 1'b0;
      #1;
   endtask

   task acc(input logic [31:0] a);
      @(posedge i_sys_clk);
      i_acc_valid <= 1'b1;
      i_acc_addr <= a;
      @(posedge i_sys_clk);
      i_acc_valid <= 1'b0;
      #1;
   endtask

   task stk(input logic push, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_push <= push;
      i_pop <= !push;
      i_push_data <= d;
      @(posedge i_sys_clk);
      i_push <= 1'b0;
      i_pop <= 1'b0;
      #1;
   endtask

   task exc(input logic e, input logic r);
      @(posedge i_sys_clk);
      i_exc_entry <= e;
      i_exc_return <= r;
      @(posedge i_sys_clk);
      i_exc_entry <= 1'b0;
      i_exc_return <= 1'b0;
      #1;
   endtask

   // mode, privilege, stack select and the active pointer in one go
   task state(input logic h, input logic p, input logic u, input logic [31:0] sp);
      chk(o_handler_mode, h);
      chk(o_privileged, p);
      chk(o_use_psp, u);
      chk(o_active_sp, sp);
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task t_boot;
      int n;
      repeat (20) @(posedge i_sys_clk);
      #1;
      chk(o_core_ready, 0);
      chk(o_privileged, 1);
      @(posedge i_sys_clk);
      i_rst <= 1'b0;
      i_vec_rd_data <= 32'h0000_1237;
      n = 0;
      while (o_vec_rd_req !== 1'b1 && n < 10) begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      if (n == 10) begin
         bad_count++;
         conclude;
      end
      chk(o_vec_rd_addr, `MPS_RESET_SP_ADDR);
      @(posedge i_sys_clk);
      i_vec_rd_valid <= 1'b1;
      @(posedge i_sys_clk);
      i_vec_rd_valid <= 1'b0;
      #1;
      chk({o_core_ready, o_vec_rd_req}, 2'h2);
      chk(o_main_stack_ptr, 32'h0000_1234);
      chk(o_ctrl_value, 2'h0);
      state(0, 1, 0, 32'h0000_1234);
      $display("test boot done");
   endtask

   task t_stack;
      stk(1, 32'hA5A5_0001);
      chk({o_stack_wr_en, o_stack_wr_addr}, 33'h1_0000_1230);
      chk(o_stack_wr_data, 32'hA5A5_0001);
      chk(o_main_stack_ptr, 32'h0000_1230);
      chk(o_process_stack_ptr, 32'h0);
      stk(0, 32'h0);
      chk(o_main_stack_ptr, 32'h0000_1234);
      ins(`MPS_IC_SREG_WR, `MPS_SR_PSP, 32'h0000_0803);
      chk(o_process_stack_ptr, 32'h0000_0800);
      ins(`MPS_IC_SREG_WR, `MPS_SR_CONTROL, 32'h3);
      chk(o_ctrl_value, 2'h3);
      state(0, 0, 1, 32'h0000_0800);
      stk(1, 32'h5A5A_0002);
      chk(o_stack_wr_addr, 32'h0000_07FC);
      chk(o_main_stack_ptr, 32'h0000_1234);
      $display("test stack done");
   endtask

   task t_unpriv;
      logic [2:0]  cls [0:5];
      logic [7:0]  sr [0:5];
      logic [5:0]  flt;
      logic [31:0] ad [0:7];
      cls = '{`MPS_IC_IRQ_MASK, `MPS_IC_SREG_RD, `MPS_IC_SREG_RD, `MPS_IC_SREG_WR,
              `MPS_IC_SREG_WR, `MPS_IC_OTHER};
      sr = '{8'h00, `MPS_SR_MSP, `MPS_SR_PSP, `MPS_SR_MSP, `MPS_SR_APSR, 8'h00};
      flt = 6'b110100;
      ad = '{`MPS_TICK_BASE, `MPS_TICK_LAST, `MPS_NIC_BASE, `MPS_NIC_LAST, `MPS_SCB_BASE,
             `MPS_SCB_LAST, 32'h0000_0FFC, 32'h0000_4000};
      for (int i = 0; i < 6; i++) begin
         ins(cls[i], sr[i], 32'h0);
         chk(o_instr_fault, flt[5-i]);
      end
      ins(`MPS_IC_SREG_WR, `MPS_SR_CONTROL, 32'h0);
      chk({o_instr_fault, o_ctrl_wr_refused, o_ctrl_value}, 4'hF);
      ins(`MPS_IC_SVC, 8'h00, 32'h0);
      chk({o_svc_req, o_instr_fault}, 2'h2);
      for (int i = 0; i < 8; i++) begin
         acc(ad[i]);
         chk(o_acc_fault, i < 6);
      end
      $display("test unprivileged done");
   endtask

   task t_exc;
      exc(1, 0);
      chk(o_nest_depth, 8'h01);
      state(1, 1, 0, 32'h0000_1234);
      acc(`MPS_TICK_BASE);
      chk(o_acc_fault, 0);
      ins(`MPS_IC_IRQ_MASK, 8'h00, 32'h0);
      chk(o_instr_fault, 0);
      exc(1, 0);
      exc(0, 1);
      chk({o_handler_mode, o_nest_depth}, 9'h101);
      ins(`MPS_IC_SREG_WR, `MPS_SR_CONTROL, 32'h0);
      chk({o_ctrl_wr_refused, o_ctrl_value}, 3'h0);
      state(1, 1, 0, 32'h0000_1234);
      exc(0, 1);
      state(0, 1, 0, 32'h0000_1234);
      exc(0, 1);
      chk(o_nest_depth, 8'h00);
      $display("test exception done");
   endtask

   // ---------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------
   initial begin
      t_boot;
      t_stack;
      t_unpriv;
      t_exc;
      conclude;
   end

   // cuts a hang short well inside the cycle budget
   initial begin
      #100000;
      bad_count++;
      conclude;
   end
endmodule // cpu_mode_privilege_stack_select_tb
